// ### rtl/usc_baud_gen.sv
// bit-rate ticks: fixed shift clock, oscillator division and timer overflow selection
`timescale 1ns/1ps
`default_nettype none
module usc_baud_gen (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	input wire logic baudDoubleBit,
	input wire logic txClockSourceSelect,
	input wire logic rxClockSourceSelect,
	input wire logic timer1Ovf,
	input wire logic timer2Ovf,
	output logic m0Tick,
	output logic m0ClkLow,
	output logic txTick,
	output logic rxTick
);
	logic [3:0] m0Cnt_r;
	logic [2:0] m2Cnt_r;
	logic t1Half_r;

	wire [2:0] m2Div = baudDoubleBit ? usc_pkg::MODE2_DIV_FAST : usc_pkg::MODE2_DIV_SLOW; // R13
	wire m2Tick = (m2Cnt_r == m2Div - 3'h1);
	// timer overflows at half rate unless doubled: sixteen ticks per bit
	wire t1Tick = timer1Ovf && (baudDoubleBit || t1Half_r); // R15 R18
	wire isMode2 = (mode == usc_pkg::MODE2);

	assign m0Tick = (m0Cnt_r == usc_pkg::MODE0_DIV - 4'h1); // R12
	assign m0ClkLow = (m0Cnt_r < usc_pkg::MODE0_HALF);
	// timer 2 in its rate mode already divides; each overflow is one tick
	assign txTick = isMode2 ? m2Tick : (txClockSourceSelect ? timer2Ovf : t1Tick); // R14 R15
	assign rxTick = isMode2 ? m2Tick : (rxClockSourceSelect ? timer2Ovf : t1Tick); // R14 R15

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			m0Cnt_r <= '0;
			m2Cnt_r <= '0;
			t1Half_r <= 1'b0;
		end else begin
			m0Cnt_r <= m0Tick ? 4'h0 : m0Cnt_r + 4'h1;
			m2Cnt_r <= m2Tick ? 3'h0 : m2Cnt_r + 3'h1;
			if (timer1Ovf) begin
				t1Half_r <= !t1Half_r; // R17
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/usc_fifo.sv
// small first-in first-out store for transmit words
`timescale 1ns/1ps
`default_nettype none
module usc_fifo #(
	parameter int WIDTH = usc_pkg::FIFO_WIDTH,
	parameter int DEPTH = usc_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
			$error("usc_fifo: depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;

	wire ptrLowEq = wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0];
	wire isEmpty = ptrLowEq && (wrPtr_r[AW] == rdPtr_r[AW]);
	wire isFull = ptrLowEq && (wrPtr_r[AW] != rdPtr_r[AW]);
	wire doPush = inValid && !isFull;
	wire doPop = outReady && !isEmpty;

	assign inReady = !isFull;
	assign outValid = !isEmpty;
	assign outData = mem[rdPtr_r[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (doPush) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			if (doPush) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (doPop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/usc_pkg.sv
// constants, types and shared values for the serial port control and bit-rate block
// Function
// R1: mode field high bit first: 00 mode 0, 01 mode 1, 10 mode 2, 11 mode 3.
// R2: in mode 0 the filter enable does nothing; software should keep it 0.
// R3: mode 1 filter on: receive flag only if stop bit is 1; off: stop ignored.
// R4: modes 2/3 filter on: receive flag only if ninth bit is 1; off: ignored.
// R5: nothing is received while receive enable is 0.
// R6: transmit ninth-bit field is the ninth sent bit in modes 2/3 only.
// R7: receive ninth bit: unused mode 0, stop level mode 1, ninth bit modes 2/3.
// R8: transmit flag set at end of bit 8 in mode 0, at stop start otherwise.
// R9: receive flag set at end of bit 8 in mode 0, mid stop otherwise, filtered.
// R10: hardware never clears the two done flags; software clears them by writing.
// R11: control register at D8h, mode high at bit 7 down to flag at bit 0, reset 00h.
// R12: mode 0 bit rate is oscillator divided by 12, whatever else is set.
// R13: mode 2 rate is oscillator /64 with doubling bit 0, /32 with it 1.
// R14: modes 1 and 3 take their rate from timer 1 or timer 2 overflows.
// R15: both clock selects 0 use timer 1; rate is 2^double/32 times overflow rate.
// R16: software keeps the timer 1 interrupt off while it clocks the port.
// R17: source timer may run as timer or counter in any running mode.
// R18: timer 1 auto-reload: rate 2^double/32 * osc/(12*(256-reload byte)).
// R19: writing the data buffer starts a transmission in every mode.
// R20: mode 0 receive starts on flag 0 and enable 1; others on start bit if enabled.
// R21: async receive takes three mid-bit samples and keeps the two-of-three value.
// R22: a software write setting a done flag raises the interrupt like hardware does.
// R23: changing mode or rate source mid-frame is undefined; frame may finish or drop.
package usc_pkg;

	localparam logic [7:0] SFR_CTRL_ADDR = 8'hD8;
	localparam logic [7:0] SFR_DATA_ADDR = 8'hD9;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_MP_FILTER = 5;
	localparam int BIT_RX_ENABLE = 4;
	localparam int BIT_TX_NINTH = 3;
	localparam int BIT_RX_NINTH = 2;
	localparam int BIT_TX_DONE = 1;
	localparam int BIT_RX_DONE = 0;

	typedef enum logic [1:0] {
		MODE0 = 2'b00,
		MODE1 = 2'b01,
		MODE2 = 2'b10,
		MODE3 = 2'b11
	} usc_mode_t;

	localparam logic [3:0] MODE0_DIV = 4'hC;
	localparam logic [3:0] MODE0_HALF = 4'h6;
	localparam logic [2:0] MODE2_DIV_SLOW = 3'h4;
	localparam logic [2:0] MODE2_DIV_FAST = 3'h2;

	localparam logic [3:0] SUB_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;

	localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
	localparam logic [3:0] STOP_IDX_8BIT = 4'h9;
	localparam logic [3:0] STOP_IDX_9BIT = 4'hA;

	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 9;

endpackage

// ### rtl/usc_uart_ctrl.sv
// second serial port: control register, transmitter, receiver and bit-rate selection
`timescale 1ns/1ps
`default_nettype none
module usc_uart_ctrl (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrWrData,
	output logic [7:0] sfrRdData,
	output logic sfrWrReady,
	input wire logic baudDoubleBit,
	input wire logic txClockSourceSelect,
	input wire logic rxClockSourceSelect,
	input wire logic timer1Ovf,
	input wire logic timer2Ovf,
	input wire logic rxdIn,
	output logic rxdOut,
	output logic rxdOe,
	output logic txdOut,
	output logic serialIrq
);
	typedef enum {TX_IDLE, TX_ASYNC, TX_SYNC} usc_tx_state_t;
	typedef enum {RX_IDLE, RX_ASYNC, RX_SYNC} usc_rx_state_t;

	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] rxBuf_r;
	usc_tx_state_t txState_r;
	usc_rx_state_t rxState_r;

	// register decode
	wire ctrlSel = (sfrAddr == usc_pkg::SFR_CTRL_ADDR); // R11
	wire dataSel = (sfrAddr == usc_pkg::SFR_DATA_ADDR);
	wire ctrlWr = sfrWrEn && ctrlSel;
	wire dataWr = sfrWrEn && dataSel;

	wire [1:0] modeBits = {ctrl_r[usc_pkg::BIT_MODE_HI], ctrl_r[usc_pkg::BIT_MODE_LO]}; // R1
	wire isMode0 = (modeBits == usc_pkg::MODE0);
	wire isMode1 = (modeBits == usc_pkg::MODE1);
	wire nineBit = modeBits[1];
	wire mpFilter = ctrl_r[usc_pkg::BIT_MP_FILTER];
	wire rxEnable = ctrl_r[usc_pkg::BIT_RX_ENABLE];
	wire txNinth = ctrl_r[usc_pkg::BIT_TX_NINTH];
	wire txDone = ctrl_r[usc_pkg::BIT_TX_DONE];
	wire rxDone = ctrl_r[usc_pkg::BIT_RX_DONE];

	// bit-rate ticks
	logic m0Tick;
	logic m0ClkLow;
	logic txTick;
	logic rxTick;

	usc_baud_gen u_baud (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mode(modeBits),
		.baudDoubleBit(baudDoubleBit),
		.txClockSourceSelect(txClockSourceSelect),
		.rxClockSourceSelect(rxClockSourceSelect),
		.timer1Ovf(timer1Ovf),
		.timer2Ovf(timer2Ovf),
		.m0Tick(m0Tick),
		.m0ClkLow(m0ClkLow),
		.txTick(txTick),
		.rxTick(rxTick)
	);

	// transmit words wait here; the ninth bit is taken at the moment of the write
	logic fifoInReady;
	logic fifoOutValid;
	logic [8:0] fifoOutData;
	wire txIdle = (txState_r == TX_IDLE);
	wire rxIdle = (rxState_r == RX_IDLE);
	// mode 0 starts on a period boundary, else bit 0 may get no rising shift clock
	wire m0Align = !isMode0 || m0Tick;
	// mode 0 shares the data pin, so a queued word waits for a running sync receive
	wire txStart = txIdle && fifoOutValid && m0Align && !(isMode0 && !rxIdle); // R19

	usc_fifo #(
		.WIDTH(usc_pkg::FIFO_WIDTH),
		.DEPTH(usc_pkg::FIFO_DEPTH)
	) u_txfifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.inValid(dataWr),
		.inReady(fifoInReady),
		.inData({txNinth, sfrWrData}),
		.outValid(fifoOutValid),
		.outReady(txStart),
		.outData(fifoOutData)
	);

	assign sfrWrReady = dataSel ? fifoInReady : 1'b1;

	// receive pin: three stages, a level change counts once stages two and three agree
	logic rxdS1_r;
	logic rxdS2_r;
	logic rxdS3_r;
	logic rxdLvl_r;
	logic rxdPrev_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rxdS1_r <= 1'b1;
			rxdS2_r <= 1'b1;
			rxdS3_r <= 1'b1;
			rxdLvl_r <= 1'b1;
			rxdPrev_r <= 1'b1;
		end else begin
			rxdS1_r <= rxdIn;
			rxdS2_r <= rxdS1_r;
			rxdS3_r <= rxdS2_r;
			if (rxdS2_r == rxdS3_r) begin
				rxdLvl_r <= rxdS3_r;
			end
			rxdPrev_r <= rxdLvl_r;
		end
	end

	wire rxdFall = rxdPrev_r && !rxdLvl_r;

	// transmitter
	logic [10:0] txShift_r;
	logic [3:0] txBit_r;
	logic [3:0] txSub_r;

	// stop position follows the live mode field, so a mid-frame mode change is undefined
	function automatic logic [3:0] stopIndex(input logic nine);
		return nine ? usc_pkg::STOP_IDX_9BIT : usc_pkg::STOP_IDX_8BIT;
	endfunction

	wire [3:0] txStopIdx = stopIndex(nineBit); // R23
	// ninth field only reaches the line in the nine-bit modes
	wire txNinthOut = nineBit ? fifoOutData[8] : 1'b1; // R6
	// async frames start at once, not on a tick boundary: the start bit may run short
	wire txBitEnd = (txState_r == TX_ASYNC) && txTick && (txSub_r == usc_pkg::SUB_LAST);
	wire txSyncEnd = (txState_r == TX_SYNC) && m0Tick;
	wire txToStop = txBitEnd && (txBit_r + 4'h1 == txStopIdx);
	wire txSyncLast = txSyncEnd && (txBit_r == usc_pkg::SYNC_LAST_BIT);
	wire tiSet = txToStop || txSyncLast; // R8

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			txState_r <= TX_IDLE;
			txShift_r <= '1;
			txBit_r <= '0;
			txSub_r <= '0;
		end else begin
			case (txState_r)
				TX_IDLE: begin
					if (txStart && isMode0) begin
						txState_r <= TX_SYNC;
						txShift_r <= {3'b111, fifoOutData[7:0]};
						txBit_r <= '0;
					end else if (txStart) begin
						txState_r <= TX_ASYNC;
						txShift_r <= {1'b1, txNinthOut, fifoOutData[7:0], 1'b0};
						txBit_r <= '0;
						txSub_r <= '0;
					end
				end
				TX_ASYNC: begin
					if (txTick) begin
						txSub_r <= txSub_r + 4'h1;
					end
					if (txBitEnd) begin
						txShift_r <= {1'b1, txShift_r[10:1]};
						txBit_r <= txBit_r + 4'h1;
						if (txBit_r == txStopIdx) begin
							txState_r <= TX_IDLE;
						end
					end
				end
				TX_SYNC: begin
					if (txSyncEnd) begin
						txShift_r <= {1'b1, txShift_r[10:1]};
						txBit_r <= txBit_r + 4'h1;
						if (txSyncLast) begin
							txState_r <= TX_IDLE;
						end
					end
				end
				default: begin
					txState_r <= TX_IDLE;
				end
			endcase
		end
	end

	// receiver
	logic [7:0] rxData_r;
	logic rxNinth_r;
	logic [3:0] rxBit_r;
	logic [3:0] rxSub_r;
	logic [1:0] rxSmp_r;

	wire rxAsync = (rxState_r == RX_ASYNC);
	wire rxVoteTick = rxAsync && rxTick && (rxSub_r == usc_pkg::SAMPLE_C);
	wire rxVote = (rxSmp_r[0] && rxSmp_r[1]) || (rxSmp_r[0] && rxdLvl_r) ||
		(rxSmp_r[1] && rxdLvl_r); // R21
	wire [3:0] rxStopIdx = stopIndex(nineBit); // R23
	wire rxStartBad = rxVoteTick && (rxBit_r == 4'h0) && rxVote;
	wire rxAtStop = rxVoteTick && (rxBit_r == rxStopIdx);
	wire rxIsData = (rxBit_r != 4'h0) && (rxBit_r <= 4'h8);
	// mode 1 checks the stop level, modes 2 and 3 the ninth bit
	wire rxFilterBit = isMode1 ? rxVote : rxNinth_r; // R3 R4
	// a frame that meets a still-set flag is lost; software must clear it in time
	wire rxAccept = rxAtStop && !rxDone && (!mpFilter || rxFilterBit); // R3 R4 R9
	wire rxSyncBit = (rxState_r == RX_SYNC) && m0Tick;
	wire rxSyncLast = rxSyncBit && (rxBit_r == usc_pkg::SYNC_LAST_BIT);
	wire riSet = rxAccept || rxSyncLast; // R9
	wire rb8Val = isMode1 ? rxVote : rxNinth_r; // R7
	wire syncRxGo = isMode0 && rxEnable && !rxDone && txIdle && !fifoOutValid && m0Align; // R20

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rxState_r <= RX_IDLE;
			rxData_r <= '0;
			rxNinth_r <= 1'b0;
			rxBit_r <= '0;
			rxSub_r <= '0;
			rxSmp_r <= '0;
		end else if (!rxEnable) begin
			rxState_r <= RX_IDLE; // R5
		end else begin
			case (rxState_r)
				RX_IDLE: begin
					rxBit_r <= '0;
					rxSub_r <= '0;
					if (syncRxGo) begin
						rxState_r <= RX_SYNC; // R20
					end else if (!isMode0 && rxdFall) begin
						rxState_r <= RX_ASYNC; // R20
					end
				end
				RX_ASYNC: begin
					if (rxTick) begin
						rxSub_r <= rxSub_r + 4'h1;
						if (rxSub_r == usc_pkg::SAMPLE_A) begin
							rxSmp_r[0] <= rxdLvl_r;
						end
						if (rxSub_r == usc_pkg::SAMPLE_B) begin
							rxSmp_r[1] <= rxdLvl_r;
						end
					end
					if (rxVoteTick) begin
						rxBit_r <= rxBit_r + 4'h1;
						if (rxIsData) begin
							rxData_r <= {rxVote, rxData_r[7:1]};
						end
						if (nineBit && rxBit_r == 4'h9) begin
							rxNinth_r <= rxVote;
						end
					end
					// a false start or a finished frame returns to hunting at once
					if (rxStartBad || rxAtStop) begin
						rxState_r <= RX_IDLE;
					end
				end
				RX_SYNC: begin
					if (rxSyncBit) begin
						rxData_r <= {rxdLvl_r, rxData_r[7:1]};
						rxBit_r <= rxBit_r + 4'h1;
						if (rxSyncLast) begin
							rxState_r <= RX_IDLE;
						end
					end
				end
				default: begin
					rxState_r <= RX_IDLE;
				end
			endcase
		end
	end

	// receive buffer, loaded only when the frame passes the filter
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rxBuf_r <= '0;
		end else if (rxAccept) begin
			rxBuf_r <= {rxData_r[7:1], rxData_r[0]};
		end else if (rxSyncLast) begin
			rxBuf_r <= {rxdLvl_r, rxData_r[7:1]};
		end
	end

	// control register; a hardware set in the same cycle as a clearing write wins
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrlWr) begin
			ctrl_nxt = sfrWrData; // R10 R22
		end
		if (rxAccept) begin
			ctrl_nxt[usc_pkg::BIT_RX_NINTH] = rb8Val; // R7
		end
		if (tiSet) begin
			ctrl_nxt[usc_pkg::BIT_TX_DONE] = 1'b1; // R8
		end
		if (riSet) begin
			ctrl_nxt[usc_pkg::BIT_RX_DONE] = 1'b1; // R9
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_r <= usc_pkg::CTRL_RESET; // R11
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// registered read port
	wire [7:0] rdMux = ctrlSel ? ctrl_r : (dataSel ? rxBuf_r : 8'h00);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sfrRdData <= 8'h00;
		end else if (sfrRdEn) begin
			sfrRdData <= rdMux;
		end
	end

	// pins: mode 0 puts data on the receive pin and the shift clock on the transmit pin
	wire syncActive = (txState_r == TX_SYNC) || (rxState_r == RX_SYNC);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			txdOut <= 1'b1;
			rxdOut <= 1'b1;
			rxdOe <= 1'b0;
		end else begin
			txdOut <= syncActive ? !m0ClkLow : txShift_r[0];
			rxdOut <= txShift_r[0];
			rxdOe <= (txState_r == TX_SYNC);
		end
	end

	// level request: it stays up until software clears both flags
	assign serialIrq = txDone || rxDone; // R22
endmodule
`default_nettype wire

// ### testbench/usc_peer.sv
// far-side serial model: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module usc_peer (
	input wire logic ref_clk,
	input wire logic txdOut,
	input wire logic rxdOut,
	input wire logic rxdOe,
	output var logic rxdIn
);
	// idle line rests high, as a pulled-up line would
	initial rxdIn = 1'h1;
	task automatic send(input logic [8:0] w, input int clks);
		@(negedge ref_clk);
		rxdIn = 1'h0;
		repeat (clks) @(negedge ref_clk);
		for (int i = 0; i < 9; i++) begin
			rxdIn = w[i];
			repeat (clks) @(negedge ref_clk);
		end
		rxdIn = 1'h1;
		repeat (clks) @(negedge ref_clk);
	endtask
	// x on timeout so the caller's compare fails
	task automatic recv(output logic [9:0] w, input int clks);
		int n;
		w = 'x;
		n = 0;
		while (txdOut !== 1'h0 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 3000)
			return;
		repeat (clks / 2) @(negedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			repeat (clks) @(negedge ref_clk);
			w[i] = txdOut;
		end
	endtask
	task automatic m0recv(output logic [7:0] d);
		int n;
		n = 0;
		for (int i = 0; i < 8; i++) begin
			while (txdOut !== 1'h0 && n < 900) begin
				@(negedge ref_clk);
				n++;
			end
			while (txdOut !== 1'h1 && n < 900) begin
				@(negedge ref_clk);
				n++;
			end
			d[i] = (n < 900 && rxdOe) ? rxdOut : 1'hx;
		end
	endtask
	// mode 0 receive: next bit goes on the data line after each falling shift clock
	task automatic m0send(input logic [7:0] d);
		int n;
		n = 0;
		for (int i = 0; i < 8; i++) begin
			while (txdOut !== 1'h0 && n < 900) begin
				@(negedge ref_clk);
				n++;
			end
			rxdIn = d[i];
			while (txdOut !== 1'h1 && n < 900) begin
				@(negedge ref_clk);
				n++;
			end
		end
		// hold the last bit past the end-of-period sample
		repeat (12) @(negedge ref_clk);
		rxdIn = 1'h1;
	endtask
endmodule
`default_nettype wire

// ### testbench/usc_uart_ctrl_props.sv
// concurrent checks on the serial port control block ports
`timescale 1ns/1ps
`default_nettype none
module usc_uart_ctrl_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrWrData,
	input wire logic [7:0] sfrRdData,
	input wire logic sfrWrReady,
	input wire logic rxdOut,
	input wire logic rxdOe,
	input wire logic txdOut,
	input wire logic serialIrq
);
	logic [7:3] ctrlHi_r;
	wire logic ctrlWr = sfrWrEn && sfrAddr == 8'hD8;
	// hardware never alters bits 7:3, so a write shadow predicts them
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			ctrlHi_r <= 5'h00;
		else if (ctrlWr)
			ctrlHi_r <= sfrWrData[7:3];
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_rstVal;
		$rose(rst_n) |-> txdOut && rxdOut && !rxdOe && !serialIrq && sfrRdData == 8'h00;
	endproperty
	a_rstVal: assert property (p_rstVal)
		else $error("outputs off reset values");
	property p_rdCtrl;
		sfrRdEn && !sfrWrEn && sfrAddr == 8'hD8 |=> sfrRdData[7:3] == $past(ctrlHi_r);
	endproperty
	a_rdCtrl: assert property (p_rdCtrl)
		else $error("control readback wrong");
	property p_rdUnmap;
		sfrRdEn && sfrAddr != 8'hD8 && sfrAddr != 8'hD9 |=> sfrRdData == 8'h00;
	endproperty
	a_rdUnmap: assert property (p_rdUnmap)
		else $error("unmapped read not zero");
	property p_irqHold;
		serialIrq && !ctrlWr |=> serialIrq;
	endproperty
	a_irqHold: assert property (p_irqHold)
		else $error("done flag dropped by hardware");
	property p_swSet;
		ctrlWr && sfrWrData[1:0] != 2'h0 |=> serialIrq;
	endproperty
	a_swSet: assert property (p_swSet)
		else $error("written flag gave no request");
	property p_wrReady;
		sfrAddr != 8'hD9 |-> sfrWrReady;
	endproperty
	a_wrReady: assert property (p_wrReady)
		else $error("write refused off data address");
	property p_oeMode0;
		rxdOe |-> ctrlHi_r[7:6] == 2'h0;
	endproperty
	a_oeMode0: assert property (p_oeMode0)
		else $error("receive pin driven outside mode 0");
	property p_m0Clk;
		$fell(txdOut) && $past(rxdOe) |-> !txdOut [*6] ##1 txdOut;
	endproperty
	a_m0Clk: assert property (p_m0Clk)
		else $error("shift clock low phase not 6");
	c_m0: cover property ($fell(txdOut) && rxdOe);
	c_async: cover property ($fell(txdOut) && !rxdOe);
	c_irq: cover property ($rose(serialIrq));
endmodule
bind usc_uart_ctrl usc_uart_ctrl_chk i_chk (.ref_clk, .rst_n, .sfrAddr, .sfrWrEn, .sfrRdEn,
	.sfrWrData, .sfrRdData, .sfrWrReady, .rxdOut, .rxdOe, .txdOut, .serialIrq);
`default_nettype wire

// ### testbench/usc_uart_ctrl_tb.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module usc_uart_ctrl_tb;
	logic refClk = 1'h0;
	logic rstN = 1'h0;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWrEn = 1'h0;
	logic sfrRdEn = 1'h0;
	logic dbl = 1'h0;
	logic txSel = 1'h0;
	logic rxSel = 1'h0;
	logic t1Ovf = 1'h0;
	logic t2Ovf = 1'h0;
	logic [7:0] rdData;
	logic wrReady, rxdIn, rxdOut, rxdOe, txdOut, serialIrq;
	logic [9:0] w;
	logic [7:0] d;
	int nErrors = 0;
	int testsRun = 0;
	int cnt = 0;
	logic [7:0] txCtrl [5] = '{8'h80, 8'hC8, 8'hC0, 8'h40, 8'h48};
	logic [1:0] txSrc [5] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h0};
	int txClk [5] = '{32, 64, 32, 32, 128};
	logic [7:0] rxCtrl [6] = '{8'hB0, 8'hB0, 8'h90, 8'h80, 8'h70, 8'h70};
	logic [7:0] rxExp [6] = '{8'hB0, 8'hB5, 8'h91, 8'h80, 8'h70, 8'h75};
	logic [5:0] rxB8 = 6'h2A;
	usc_uart_ctrl i_dut (.ref_clk(refClk), .rst_n(rstN), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(rdData), .sfrWrReady(wrReady),
		.baudDoubleBit(dbl), .txClockSourceSelect(txSel), .rxClockSourceSelect(rxSel),
		.timer1Ovf(t1Ovf), .timer2Ovf(t2Ovf), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.txdOut(txdOut), .serialIrq(serialIrq));
	usc_peer i_peer (.ref_clk(refClk), .txdOut(txdOut), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.rxdIn(rxdIn));
	always #5 refClk = ~refClk;
	// timer 1 overflows every 4 clocks, timer 2 every 2
	always @(negedge refClk) begin
		cnt++;
		t1Ovf = (cnt % 4 == 0);
		t2Ovf = (cnt % 2 == 0);
	end
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		testsRun++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		int n;
		n = 0;
		@(negedge refClk);
		sfrAddr = a;
		sfrWrData = v;
		sfrWrEn = 1'h1;
		// a full queue drops the write, so hold it until there is room
		while (!wrReady && n < 2000) begin
			@(negedge refClk);
			n++;
		end
		if (!wrReady)
			chk("write ready", 10'h001, {9'h000, wrReady});
		@(negedge refClk);
		sfrWrEn = 1'h0;
	endtask
	task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] e);
		@(negedge refClk);
		sfrAddr = a;
		sfrRdEn = 1'h1;
		@(negedge refClk);
		sfrRdEn = 1'h0;
		chk(what, {2'h0, e}, {2'h0, rdData});
	endtask
	task automatic printVerdict;
		$display("checks %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge refClk);
		nErrors++;
		printVerdict();
	end
	initial begin
		repeat (5) @(negedge refClk);
		rstN = 1'h1;
		rdChk("ctrl reset", 8'hD8, 8'h00);
		rdChk("unmapped", 8'h20, 8'h00);
		wr(8'hD8, 8'hF8);
		rdChk("ctrl rw", 8'hD8, 8'hF8);
		wr(8'hD8, 8'h88);
		fork
			begin
				for (int i = 0; i < 5; i++)
					wr(8'hD9, 8'h51 + 8'h11 * i[7:0]);
				chk("fifo full", 10'h000, {9'h000, wrReady});
			end
			for (int i = 0; i < 5; i++) begin
				i_peer.recv(w, 64);
				chk("fifo frame", {2'h3, 8'h51 + 8'h11 * i[7:0]}, w);
				chk("tx irq", 10'h001, {9'h000, serialIrq});
			end
		join
		rdChk("tx done", 8'hD8, 8'h8A);
		wr(8'hD8, 8'h88);
		chk("irq clear", 10'h000, {9'h000, serialIrq});
		wr(8'hD8, 8'h8A);
		chk("irq sw", 10'h001, {9'h000, serialIrq});
		for (int k = 0; k < 5; k++) begin
			// let the previous stop bit finish before changing rate source
			repeat (140) @(negedge refClk);
			{dbl, txSel} = txSrc[k];
			wr(8'hD8, txCtrl[k]);
			d = 8'h96 ^ k[7:0];
			fork
				i_peer.recv(w, txClk[k]);
				wr(8'hD9, d);
			join
			chk("tx rate", {1'h1, txCtrl[k][7] ? txCtrl[k][3] : 1'h1, d}, w);
		end
		repeat (140) @(negedge refClk);
		{dbl, rxSel} = 2'h3;
		for (int k = 0; k < 6; k++) begin
			wr(8'hD8, rxCtrl[k]);
			d = 8'h3A + k[7:0];
			i_peer.send({rxB8[k], d}, 32);
			rdChk("rx flags", 8'hD8, rxExp[k]);
			if (rxExp[k][0])
				rdChk("rx data", 8'hD9, d);
		end
		wr(8'hD8, 8'h00);
		fork
			i_peer.m0recv(d);
			wr(8'hD9, 8'h5A);
		join
		chk("mode0 data", 10'h05A, {2'h0, d});
		repeat (30) @(negedge refClk);
		rdChk("mode0 done", 8'hD8, 8'h02);
		wr(8'hD8, 8'h10);
		i_peer.m0send(8'hC3);
		rdChk("mode0 rx flags", 8'hD8, 8'h11);
		rdChk("mode0 rx data", 8'hD9, 8'hC3);
		printVerdict();
	end
endmodule
`default_nettype wire
